// ### adcc_map.svh
/*
  register offsets, field positions, reset values and fixed counts of the converter control block.
  assumes a 32-bit byte address bus with word-aligned registers.
*/
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADCC_OFS_CTRL 32'hFFFF0500
`define ADCC_OFS_POSCH 32'hFFFF0504
`define ADCC_OFS_NEGCH 32'hFFFF0508
`define ADCC_OFS_STAT 32'hFFFF050C
`define ADCC_OFS_RESULT 32'hFFFF0510
`define ADCC_OFS_REGRST 32'hFFFF0514
`define ADCC_OFS_IMASK 32'hFFFF0518
`define ADCC_OFS_ISTAT 32'hFFFF051C
`define ADCC_OFS_PCFG 32'hFFFF0520
// ----------------------------------------
// fields and values
// ----------------------------------------
`define ADCC_CTRL_RST 16'h0A00
`define ADCC_DIV_HI 13
`define ADCC_DIV_LO 11
`define ADCC_ACQ_HI 10
`define ADCC_ACQ_LO 8
`define ADCC_ENA_BIT 7
`define ADCC_PWR_BIT 5
`define ADCC_MODE_HI 4
`define ADCC_MODE_LO 3
`define ADCC_TRIG_HI 2
`define ADCC_TRIG_LO 0
`define ADCC_MODE_DIFF 2'h1
`define ADCC_TRIG_PIN 3'h0
`define ADCC_TRIG_TMR1 3'h1
`define ADCC_TRIG_TMR0 3'h2
`define ADCC_TRIG_SINGLE 3'h3
`define ADCC_TRIG_CONT 3'h4
`define ADCC_TRIG_PLA 3'h5
`define ADCC_CH_TEMP 5'h0D
`define ADCC_TEMP_DIV 3'h5
`define ADCC_TEMP_ACQ 3'h3
`define ADCC_CODE_MAX 3'h5
`define ADCC_EXTRA_CLKS 7'h13
`define ADCC_RES_LO 16
`define ADCC_RES_HI 27
`endif

// ### adcc_pkg.sv
/*
  types of the converter control block.
  assumes nothing of its surroundings.
*/
package adcc_pkg;
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_ACQ, ADCC_CONV} adcc_state_t;
endpackage

// ### adcc_top.sv
/*
  converter control and sequencing: control registers, divider, acquisition and
  bit-trial timing, ready flag, interrupt and busy output.
  assumes the analog core holds its 12-bit answer valid when the last converter clock ends,
  timer and logic-array triggers come from the same clock, the external trigger is a pin.
*/
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_top
(
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic [31:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic CONVERT_PIN_I,
  input wire logic TIMER0_I,
  input wire logic TIMER1_I,
  input wire logic PLA_I,
  input wire logic [11:0] ANA_RESULT_I,
  output logic ANA_POWER_O,
  output logic [1:0] ANA_MODE_O,
  output logic [4:0] ANA_POS_CH_O,
  output logic [4:0] ANA_NEG_CH_O,
  output logic ANA_SAMPLE_O,
  output logic CONV_BUSY_O,
  output logic PORT0_BIT2_O,
  output logic IRQ_O
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  // divider code to core clocks per converter clock; reserved codes fall back to /32
  function automatic logic [5:0] div_len(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `ADCC_CODE_MAX) ? `ADCC_CODE_MAX : code;
    div_len = 6'h01 << c;
  endfunction
  // acquisition code to converter clocks
  function automatic logic [6:0] acq_len(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `ADCC_CODE_MAX) ? `ADCC_CODE_MAX : code;
    acq_len = 7'h02 << c;
  endfunction
  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic pin_meta_reg;
  logic pin_sync_reg;
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= CONVERT_PIN_I;
      pin_sync_reg <= pin_meta_reg;
    end
  end
  // ----------------------------------------
  // registers and sequencer
  // ----------------------------------------
  logic [15:0] ctrl_reg, ctrl_next;
  logic [4:0] pos_reg, pos_next;
  logic [4:0] neg_reg, neg_next;
  logic [11:0] result_reg, result_next;
  logic [1:0] rmode_reg, rmode_next;
  logic ready_reg, ready_next;
  logic imask_reg, imask_next;
  logic istat_reg, istat_next;
  logic pcfg_reg, pcfg_next;
  logic [2:0] div_sel_reg, div_sel_next;
  logic [2:0] acq_sel_reg, acq_sel_next;
  logic [5:0] div_cnt_reg, div_cnt_next;
  logic [6:0] cyc_cnt_reg, cyc_cnt_next;
  adcc_pkg::adcc_state_t state_reg, state_next;
  logic [31:0] rdata_next;
  logic wr_ctrl, wr_rst, rd_res, trig, start, tick, done;
  logic [6:0] last_cyc;
  logic [2:0] trig_sel;
  always_comb
  begin
    wr_ctrl = WR_I && (ADDR_I == `ADCC_OFS_CTRL);
    wr_rst = WR_I && (ADDR_I == `ADCC_OFS_REGRST);
    rd_res = RD_I && (ADDR_I == `ADCC_OFS_RESULT);
    trig_sel = ctrl_reg[`ADCC_TRIG_HI:`ADCC_TRIG_LO];
    unique case (trig_sel)
      `ADCC_TRIG_PIN: trig = pin_sync_reg;
      `ADCC_TRIG_TMR1: trig = TIMER1_I;
      `ADCC_TRIG_TMR0: trig = TIMER0_I;
      `ADCC_TRIG_SINGLE: trig = 1'b1;
      `ADCC_TRIG_CONT: trig = 1'b1;
      `ADCC_TRIG_PLA: trig = PLA_I;
      default: trig = 1'b0;
    endcase
    // enable and power gate any start
    start = (state_reg == adcc_pkg::ADCC_IDLE) && ctrl_reg[`ADCC_ENA_BIT]
      && ctrl_reg[`ADCC_PWR_BIT] && trig;
    tick = (div_cnt_reg == div_len(div_sel_reg) - 6'h01);
    last_cyc = acq_len(acq_sel_reg) + `ADCC_EXTRA_CLKS - 7'h01;
    done = (state_reg == adcc_pkg::ADCC_CONV) && tick && (cyc_cnt_reg == last_cyc);
    ctrl_next = ctrl_reg;
    pos_next = pos_reg;
    neg_next = neg_reg;
    result_next = result_reg;
    rmode_next = rmode_reg;
    ready_next = ready_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    pcfg_next = pcfg_reg;
    div_sel_next = div_sel_reg;
    acq_sel_next = acq_sel_reg;
    div_cnt_next = div_cnt_reg;
    cyc_cnt_next = cyc_cnt_reg;
    state_next = state_reg;
    if (start)
    begin
      // other channels take the user fields afresh
      if (pos_reg == `ADCC_CH_TEMP)
      begin
        div_sel_next = `ADCC_TEMP_DIV;
        acq_sel_next = `ADCC_TEMP_ACQ;
      end
      else
      begin
        div_sel_next = ctrl_reg[`ADCC_DIV_HI:`ADCC_DIV_LO];
        acq_sel_next = ctrl_reg[`ADCC_ACQ_HI:`ADCC_ACQ_LO];
      end
      div_cnt_next = 6'h00;
      cyc_cnt_next = 7'h00;
      rmode_next = ctrl_reg[`ADCC_MODE_HI:`ADCC_MODE_LO];
      state_next = adcc_pkg::ADCC_ACQ;
    end
    else if (state_reg != adcc_pkg::ADCC_IDLE)
    begin
      div_cnt_next = tick ? 6'h00 : div_cnt_reg + 6'h01;
      if (tick)
      begin
        cyc_cnt_next = cyc_cnt_reg + 7'h01;
        if (cyc_cnt_reg == acq_len(acq_sel_reg) - 7'h01)
          state_next = adcc_pkg::ADCC_CONV;
      end
      if (done)
        state_next = adcc_pkg::ADCC_IDLE;
    end
    if (WR_I)
    begin
      // control write steers enable, mode and trigger
      if (wr_ctrl)
        ctrl_next = WDATA_I[15:0];
      if (ADDR_I == `ADCC_OFS_POSCH)
        pos_next = WDATA_I[4:0];
      if (ADDR_I == `ADCC_OFS_NEGCH)
        neg_next = WDATA_I[4:0];
      if (ADDR_I == `ADCC_OFS_IMASK)
        imask_next = WDATA_I[0];
      if (ADDR_I == `ADCC_OFS_ISTAT && WDATA_I[0])
        istat_next = 1'b0;
      if (ADDR_I == `ADCC_OFS_PCFG)
        pcfg_next = WDATA_I[0];
    end
    if (rd_res)
      ready_next = 1'b0;
    if (done)
    begin
      result_next = ANA_RESULT_I;
      // ready and interrupt set, winning over the read and flag-write clears but not over register reset
      ready_next = 1'b1;
      istat_next = 1'b1;
      // single software conversion returns to pin trigger
      if (trig_sel == `ADCC_TRIG_SINGLE && !wr_ctrl)
        ctrl_next[`ADCC_TRIG_HI:`ADCC_TRIG_LO] = `ADCC_TRIG_PIN;
    end
    // register reset returns all to defaults and aborts
    if (wr_rst)
    begin
      ctrl_next = `ADCC_CTRL_RST;
      pos_next = 5'h00;
      neg_next = 5'h00;
      result_next = 12'h000;
      rmode_next = 2'h0;
      ready_next = 1'b0;
      imask_next = 1'b0;
      istat_next = 1'b0;
      pcfg_next = 1'b0;
      state_next = adcc_pkg::ADCC_IDLE;
    end
    rdata_next = 32'h00000000;
    if (RD_I)
    begin
      unique case (ADDR_I)
        `ADCC_OFS_CTRL: rdata_next = {16'h0000, ctrl_reg};
        `ADCC_OFS_POSCH: rdata_next = {27'h0000000, pos_reg};
        `ADCC_OFS_NEGCH: rdata_next = {27'h0000000, neg_reg};
        `ADCC_OFS_STAT: rdata_next = {31'h00000000, ready_reg};
        // differential results are two's complement, so the top bits carry the sign
        `ADCC_OFS_RESULT: rdata_next = {{4{(rmode_reg == `ADCC_MODE_DIFF) & result_reg[11]}},
          result_reg, 16'h0000};
        `ADCC_OFS_IMASK: rdata_next = {31'h00000000, imask_reg};
        `ADCC_OFS_ISTAT: rdata_next = {31'h00000000, istat_reg};
        `ADCC_OFS_PCFG: rdata_next = {31'h00000000, pcfg_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      ctrl_reg <= `ADCC_CTRL_RST;
      pos_reg <= 5'h00;
      neg_reg <= 5'h00;
      result_reg <= 12'h000;
      rmode_reg <= 2'h0;
      ready_reg <= 1'b0;
      imask_reg <= 1'b0;
      istat_reg <= 1'b0;
      pcfg_reg <= 1'b0;
      div_sel_reg <= 3'h0;
      acq_sel_reg <= 3'h0;
      div_cnt_reg <= 6'h00;
      cyc_cnt_reg <= 7'h00;
      state_reg <= adcc_pkg::ADCC_IDLE;
      RDATA_O <= 32'h00000000;
      ANA_SAMPLE_O <= 1'b0;
      CONV_BUSY_O <= 1'b0;
      PORT0_BIT2_O <= 1'b0;
      IRQ_O <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      result_reg <= result_next;
      rmode_reg <= rmode_next;
      ready_reg <= ready_next;
      imask_reg <= imask_next;
      istat_reg <= istat_next;
      pcfg_reg <= pcfg_next;
      div_sel_reg <= div_sel_next;
      acq_sel_reg <= acq_sel_next;
      div_cnt_reg <= div_cnt_next;
      cyc_cnt_reg <= cyc_cnt_next;
      state_reg <= state_next;
      RDATA_O <= rdata_next;
      ANA_SAMPLE_O <= (state_next == adcc_pkg::ADCC_ACQ);
      CONV_BUSY_O <= (state_next != adcc_pkg::ADCC_IDLE);
      PORT0_BIT2_O <= pcfg_next && (state_next != adcc_pkg::ADCC_IDLE);
      IRQ_O <= istat_next && imask_next;
    end
  end
  // analog controls straight from the control flops
  assign ANA_POWER_O = ctrl_reg[`ADCC_PWR_BIT];
  assign ANA_MODE_O = ctrl_reg[`ADCC_MODE_HI:`ADCC_MODE_LO];
  assign ANA_POS_CH_O = pos_reg;
  assign ANA_NEG_CH_O = neg_reg;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_temp_start;
    start && (pos_reg == `ADCC_CH_TEMP);
  endsequence
  sequence s_user_start;
    start && (pos_reg != `ADCC_CH_TEMP);
  endsequence
  a_busy_state: assert property (CONV_BUSY_O == (state_reg != adcc_pkg::ADCC_IDLE))
    else $error("busy does not match sequencer");
  a_ready_set: assert property (done |=> ready_reg && istat_reg)
    else $error("ready not set at conversion end");
  a_ready_clear: assert property (rd_res && !done && !wr_rst |=> !ready_reg)
    else $error("result read did not clear ready");
  a_port_gate: assert property (!pcfg_reg |-> !PORT0_BIT2_O)
    else $error("port pin shows busy while disabled");
  a_reg_reset: assert property (wr_rst |=> ctrl_reg == `ADCC_CTRL_RST && !ready_reg)
    else $error("register reset left values");
  a_temp_timing: assert property (s_temp_start |=> div_sel_reg == `ADCC_TEMP_DIV
    && acq_sel_reg == `ADCC_TEMP_ACQ)
    else $error("temperature timing not forced");
  a_user_timing: assert property (s_user_start |=>
    div_sel_reg == $past(ctrl_reg[`ADCC_DIV_HI:`ADCC_DIV_LO]))
    else $error("user divider not restored");
  a_single_clear: assert property (done && trig_sel == `ADCC_TRIG_SINGLE && !WR_I
    |=> ctrl_reg[`ADCC_TRIG_HI:`ADCC_TRIG_LO] == `ADCC_TRIG_PIN)
    else $error("single trigger did not clear");
  a_conv_length: assert property (s_user_start ##1 (div_sel_reg == 3'h0
    && acq_sel_reg == 3'h0) |-> ##20 done)
    else $error("fastest conversion not 21 clocks");
  a_irq_level: assert property (IRQ_O == (istat_reg && imask_reg))
    else $error("interrupt level wrong");
endmodule

// ### adcc_ana_model.sv
/*
  analog core model: answers each conversion with a code built from the channel.
  assumes the block takes the answer while busy and outside acquisition.
*/
`timescale 1ns/1ps
module adcc_ana_model
(
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic sample_i,
  input wire logic [4:0] pos_ch_i,
  output logic [11:0] result_o
);
  logic [11:0] junk_reg = 12'h000;
  always_ff @(posedge clk_i)
  begin
    junk_reg <= junk_reg + 12'h3A7;
  end
  // outside bit trials the answer changes every cycle, so a stale capture shows
  assign result_o = (busy_i && !sample_i) ? (12'hA40 | {7'h00, pos_ch_i}) : ~junk_reg;
endmodule

// ### test_adc_conversion_control.sv
/*
  self-checking bench of the converter control block.
  assumes adcc_top and the analog core model beside it.
*/
`timescale 1ns/1ps
`include "adcc_map.svh"
module test_adc_conversion_control;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] addr = 32'h00000000;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b0;
  logic tmr0 = 1'b0;
  logic tmr1 = 1'b0;
  logic programmable_logic_array = 1'b0;
  logic [31:0] rdata;
  logic [11:0] ana_res;
  logic power;
  logic sample;
  logic busy;
  logic port_busy;
  logic irq;
  logic [1:0] mode;
  logic [4:0] pos_ch;
  logic [4:0] neg_ch;
  int n_samp = 0;
  int n_errors = 0;
  int n_tests = 0;
  always #5 mclk = ~mclk;
  adcc_top u_dut (.MCLK_I(mclk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .CONVERT_PIN_I(pin), .TIMER0_I(tmr0), .TIMER1_I(tmr1),
    .PLA_I(programmable_logic_array), .ANA_RESULT_I(ana_res), .ANA_POWER_O(power), .ANA_MODE_O(mode),
    .ANA_POS_CH_O(pos_ch), .ANA_NEG_CH_O(neg_ch), .ANA_SAMPLE_O(sample), .CONV_BUSY_O(busy),
    .PORT0_BIT2_O(port_busy), .IRQ_O(irq));
  adcc_ana_model u_ana (.clk_i(mclk), .busy_i(busy), .sample_i(sample), .pos_ch_i(pos_ch),
    .result_o(ana_res));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk_word(what, exp, rdata);
  endtask
  // waits for busy, then counts the cycles it stands high and the sampling cycles within
  task automatic conv_len(output int n);
    int k;
    n = 0;
    k = 0;
    n_samp = 0;
    while (busy !== 1'b1 && k < 40)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    while (busy === 1'b1 && n < 4000)
    begin
      if (sample === 1'b1)
        n_samp++;
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk("control", `ADCC_OFS_CTRL, 32'h00000A00);
    rd_chk("status", `ADCC_OFS_STAT, 32'h00000000);
    rd_chk("unmapped", 32'hFFFF0600, 32'h00000000);
    chk_word("busy", 32'h0, {31'h0, busy});
    $display("test reset done");
  endtask
  task automatic t_single(input logic [2:0] div, input logic [2:0] acq, input logic [4:0] ch);
    int n;
    int exp_len;
    int exp_acq;
    exp_len = (ch == `ADCC_CH_TEMP) ? 32 * (16 + 19) : (1 << div) * ((2 << acq) + 19);
    exp_acq = (ch == `ADCC_CH_TEMP) ? 32 * 16 : (1 << div) * (2 << acq);
    wr_reg(`ADCC_OFS_POSCH, {27'h0, ch});
    wr_reg(`ADCC_OFS_CTRL, {18'h0, div, acq, 8'hA3});
    conv_len(n);
    chk_word("busy cycles", exp_len, n);
    chk_word("sample cycles", exp_acq, n_samp);
    rd_chk("status", `ADCC_OFS_STAT, 32'h00000001);
    rd_chk("result", `ADCC_OFS_RESULT, {4'h0, 12'hA40 | {7'h00, ch}, 16'h0000});
    rd_chk("status", `ADCC_OFS_STAT, 32'h00000000);
    rd_chk("control", `ADCC_OFS_CTRL, {18'h0, div, acq, 8'hA0});
    $display("test single conversion done");
  endtask
  task automatic t_irq;
    wr_reg(`ADCC_OFS_IMASK, 32'h1);
    t_single(3'h0, 3'h0, 5'h05);
    chk_word("irq", 32'h1, {31'h0, irq});
    rd_chk("int status", `ADCC_OFS_ISTAT, 32'h1);
    wr_reg(`ADCC_OFS_ISTAT, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
    chk_word("irq", 32'h0, {31'h0, irq});
    wr_reg(`ADCC_OFS_IMASK, 32'h0);
    t_single(3'h0, 3'h0, 5'h06);
    chk_word("masked irq", 32'h0, {31'h0, irq});
    rd_chk("int status", `ADCC_OFS_ISTAT, 32'h1);
    wr_reg(`ADCC_OFS_ISTAT, 32'h1);
    $display("test interrupt done");
  endtask
  task automatic t_trig;
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
    logic [3:0] lines [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    int n;
    wr_reg(`ADCC_OFS_PCFG, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(`ADCC_OFS_CTRL, {24'h0, 5'h14, codes[i]});
      @(posedge mclk);
      {programmable_logic_array, tmr0, tmr1, pin} <= lines[i];
      fork
        conv_len(n);
        begin
          repeat (4) @(posedge mclk);
          {programmable_logic_array, tmr0, tmr1, pin} <= 4'h0;
          repeat (6) @(posedge mclk);
          #1;
          chk_word("port busy", 32'h1, {31'h0, port_busy});
        end
      join
      chk_word("trigger busy cycles", 32'd21, n);
    end
    wr_reg(`ADCC_OFS_CTRL, 32'h000000A4);
    conv_len(n);
    conv_len(n);
    chk_word("continuous second", 32'd21, n);
    wr_reg(`ADCC_OFS_CTRL, 32'h000000A6);
    conv_len(n);
    repeat (4) @(posedge mclk);
    #1;
    chk_word("reserved trigger", 32'h0, {31'h0, busy});
    wr_reg(`ADCC_OFS_CTRL, 32'h00000024);
    repeat (30) @(posedge mclk);
    #1;
    chk_word("no start", 32'h0, {31'h0, busy});
    $display("test triggers done");
  endtask
  task automatic t_diff;
    int n;
    wr_reg(`ADCC_OFS_POSCH, 32'h00000007);
    wr_reg(`ADCC_OFS_CTRL, 32'h000000AB);
    conv_len(n);
    chk_word("diff busy cycles", 32'd21, n);
    chk_word("diff mode", 32'h1, {30'h0, mode});
    rd_chk("diff result", `ADCC_OFS_RESULT, {4'hF, 12'hA47, 16'h0000});
    rd_chk("control", `ADCC_OFS_CTRL, 32'h000000A8);
    $display("test differential result done");
  endtask
  task automatic t_regrst;
    wr_reg(`ADCC_OFS_CTRL, 32'h00000528);
    wr_reg(`ADCC_OFS_POSCH, 32'h00000007);
    wr_reg(`ADCC_OFS_IMASK, 32'h00000001);
    wr_reg(`ADCC_OFS_NEGCH, 32'h0000000B);
    rd_chk("neg channel", `ADCC_OFS_NEGCH, 32'h0000000B);
    chk_word("neg channel pin", 32'hB, {27'h0, neg_ch});
    rd_chk("control", `ADCC_OFS_CTRL, 32'h00000528);
    chk_word("power", 32'h1, {31'h0, power});
    chk_word("mode", 32'h1, {30'h0, mode});
    wr_reg(`ADCC_OFS_REGRST, 32'h00000000);
    rd_chk("control", `ADCC_OFS_CTRL, 32'h00000A00);
    rd_chk("channel", `ADCC_OFS_POSCH, 32'h00000000);
    rd_chk("mask", `ADCC_OFS_IMASK, 32'h00000000);
    rd_chk("neg channel", `ADCC_OFS_NEGCH, 32'h00000000);
    rd_chk("port config", `ADCC_OFS_PCFG, 32'h00000000);
    chk_word("neg channel pin", 32'h0, {27'h0, neg_ch});
    rd_chk("status", `ADCC_OFS_STAT, 32'h00000000);
    chk_word("power", 32'h0, {31'h0, power});
    $display("test register reset done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    for (int i = 0; i < 6; i++)
    begin
      t_single(i[2:0], i[2:0], 5'h02);
    end
    t_single(3'h1, 3'h2, 5'h03);
    t_single(3'h0, 3'h0, `ADCC_CH_TEMP);
    t_single(3'h0, 3'h0, 5'h04);
    t_diff;
    t_irq;
    t_trig;
    t_regrst;
    print_verdict;
  end
  // the whole run is near 5600 cycles, so this leaves ample slack
  initial
  begin
    #400000;
    n_errors++;
    $display("watchdog expired");
    print_verdict;
  end
endmodule
